// *** core/asl_pkg.sv ***
/*
  constants and state types for the address strap and link status bank.
  assumes one 25 MHz clock shared with the frame decoder and the strap converter.
*/
`default_nettype none
package asl_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int unsigned ADDR_W           = 4;
  localparam int unsigned DATA_W           = 13;
  localparam logic [3:0]  STRAP_CODES_ADDR = 4'hc;
  localparam logic [3:0]  LINK_STATUS_ADDR = 4'hd;

  // strap code field positions
  localparam int unsigned STRAP0_LSB = 0;
  localparam int unsigned STRAP1_LSB = 4;
  localparam int unsigned STRAP2_LSB = 8;
  localparam int unsigned CODE_W     = 4;

  // link status bit positions
  localparam int unsigned WDOG_BIT       = 8;
  localparam int unsigned TIMEOUT_BIT    = 7;
  localparam int unsigned CRC_BIT        = 6;
  localparam int unsigned SYNC_PAR_BIT   = 5;
  localparam int unsigned PL_PAR_BIT     = 4;
  localparam int unsigned SYNC_STOP_BIT  = 3;
  localparam int unsigned PL_STOP_BIT    = 2;
  localparam int unsigned PL_START_BIT   = 1;
  localparam logic [8:1]  STATUS_RESET   = 8'h00;
  localparam logic [11:0] CODES_RESET    = 12'h000;
  // synchroniser and line level preset to idle high, so reset brings no false edge
  localparam logic [2:0]  SYNC_RESET     = 3'h7;
  localparam logic        LINE_IDLE      = 1'h1;

  // lowest legal strap code; below it the strap reads as shorted
  localparam logic [3:0]  STRAP_MIN_CODE = 4'h1;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned WDOG_TIME_S  = 4;
  localparam int unsigned WDOG_CYCLES  = WDOG_TIME_S * CLK_HZ;
  localparam int unsigned WDOG_CNT_W   = 27;
  localparam int unsigned TIMEOUT_BITS = 16;
  localparam int unsigned PERIOD_W     = 16;
  localparam int unsigned GAP_W        = 20;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    MEAS_IDLE,
    MEAS_FIRST,
    MEAS_SECOND,
    MEAS_RUN
  } asl_meas_t;

  typedef struct packed {
    logic [2:0]            sync;
    logic                  rxLevel;
    logic [11:0]           codes;
    logic                  sampled;
    logic                  lowFlag;
    logic [8:1]            stat;
    logic [WDOG_CNT_W-1:0] wdCnt;
    asl_meas_t             meas;
    logic [PERIOD_W-1:0]   bitPer;
    logic [GAP_W-1:0]      gapCnt;
    logic [DATA_W-1:0]     rdata;
  } asl_state_t;
endpackage
`default_nettype wire

// *** core/asl_status.sv ***
/*
  strap code register and link status register with write-one-to-clear flags,
  receive line watchdog and in-packet timeout.
  assumes the frame decoder on the same clock issues one-cycle register strobes
  and error pulses; the receive pin is asynchronous and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RQ1: flag strap 0 low when its measured code is below the minimum code.
// RQ2: latch the three 4-bit strap codes measured at power up, read only.
// RQ3: strap 2 code at bits 11:8, strap 1 at 7:4; bits 5:4 are ID high bits.
// RQ4: strap 0 code at bits 3:0 forms the four low bits of the bus ID.
// RQ5: set watchdog bit 8 after at least 4 s without receive pin activity.
// RQ6: error bits 7:1 reset to zero, stay set until host writes one.
// RQ7: set timeout bit when no receive edges for over 16 bit periods mid-packet.
// RQ8: bit period comes from the sync frame at the start of each packet.
// RQ9: flag the checksum error bit when a transaction fails its checksum.
// RQ10: sample strap codes once after reset and hold them until next reset.
module asl_status #(
  parameter int unsigned WDOG_CYCLES = asl_pkg::WDOG_CYCLES
) (
  input  wire logic                       clock,
  input  wire logic                       resetn,
  input  wire logic                       ce,
  input  wire logic                       rxPin,
  input  wire logic                       packetActive,
  input  wire logic                       strapValid,
  input  wire logic [3:0]                 strap0Value,
  input  wire logic [3:0]                 strap1Value,
  input  wire logic [3:0]                 strap2Value,
  input  wire logic                       crcErr,
  input  wire logic                       syncParityErr,
  input  wire logic                       payloadParityErr,
  input  wire logic                       syncStopErr,
  input  wire logic                       payloadStopErr,
  input  wire logic                       payloadStartErr,
  input  wire logic                       regRead,
  input  wire logic                       regWrite,
  input  wire logic [asl_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [asl_pkg::DATA_W-1:0] regWdata,
  output logic      [asl_pkg::DATA_W-1:0] regRdata,
  output logic      [5:0]                 deviceId,
  output logic                            strap0LowFlag,
  output logic                            watchdogExpired
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  localparam logic [asl_pkg::WDOG_CNT_W-1:0] WDOG_LAST = asl_pkg::WDOG_CNT_W'(WDOG_CYCLES - 1);

  asl_pkg::asl_state_t st;
  asl_pkg::asl_state_t next_st;
  logic                rxEdge;
  logic                statusWrite;
  logic [asl_pkg::GAP_W-1:0] gapLimit;

  // a change counts only once stages two and three agree
  assign rxEdge      = (st.sync[1] == st.sync[2]) && (st.sync[1] != st.rxLevel);
  assign statusWrite = regWrite && (regAddr == asl_pkg::LINK_STATUS_ADDR);
  assign gapLimit    = asl_pkg::GAP_W'(st.bitPer * asl_pkg::TIMEOUT_BITS);

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    if (ce) begin
      next_st.sync = {st.sync[1:0], rxPin};
      if (rxEdge) begin
        next_st.rxLevel = st.sync[2];
      end

      // strap codes frozen after the first sample, so the ID never moves
      if (strapValid && !st.sampled) begin // see RQ10
        next_st.codes[asl_pkg::STRAP2_LSB +: asl_pkg::CODE_W] = strap2Value; // see RQ2 see RQ3
        next_st.codes[asl_pkg::STRAP1_LSB +: asl_pkg::CODE_W] = strap1Value; // see RQ3
        next_st.codes[asl_pkg::STRAP0_LSB +: asl_pkg::CODE_W] = strap0Value; // see RQ4
        next_st.lowFlag = strap0Value < asl_pkg::STRAP_MIN_CODE; // see RQ1
        next_st.sampled = 1'b1;
      end

      // read answer one cycle after the strobe
      if (regRead) begin
        if (regAddr == asl_pkg::STRAP_CODES_ADDR) begin
          next_st.rdata = {1'b0, st.codes}; // see RQ2
        end else if (regAddr == asl_pkg::LINK_STATUS_ADDR) begin
          next_st.rdata = {4'h0, st.stat, 1'b0};
        end else begin
          next_st.rdata = '0;
        end
      end

      // clear first, sets below so a same-cycle event wins
      if (statusWrite) begin
        next_st.stat = st.stat & ~regWdata[asl_pkg::WDOG_BIT:asl_pkg::PL_START_BIT]; // see RQ6
      end
      if (crcErr) begin
        next_st.stat[asl_pkg::CRC_BIT] = 1'b1; // see RQ9
      end
      if (syncParityErr) begin
        next_st.stat[asl_pkg::SYNC_PAR_BIT] = 1'b1;
      end
      if (payloadParityErr) begin
        next_st.stat[asl_pkg::PL_PAR_BIT] = 1'b1;
      end
      if (syncStopErr) begin
        next_st.stat[asl_pkg::SYNC_STOP_BIT] = 1'b1;
      end
      if (payloadStopErr) begin
        next_st.stat[asl_pkg::PL_STOP_BIT] = 1'b1;
      end
      if (payloadStartErr) begin
        next_st.stat[asl_pkg::PL_START_BIT] = 1'b1;
      end

      // watchdog saturates, so the bit re-sets after a clear while the line stays idle
      if (rxEdge) begin
        next_st.wdCnt = '0;
      end else if (st.wdCnt != WDOG_LAST) begin
        next_st.wdCnt = st.wdCnt + 1'b1;
      end else begin
        next_st.stat[asl_pkg::WDOG_BIT] = 1'b1; // see RQ5
      end

      // gap counter saturates rather than wraps
      if (rxEdge) begin
        next_st.gapCnt = '0;
      end else if (st.gapCnt != '1) begin
        next_st.gapCnt = st.gapCnt + 1'b1;
      end

      // sync frame alternates, so two edges apart is one bit period
      unique case (st.meas)
        asl_pkg::MEAS_IDLE: begin
          if (packetActive) begin
            next_st.meas = asl_pkg::MEAS_FIRST;
          end
        end
        asl_pkg::MEAS_FIRST: begin
          if (rxEdge) begin
            next_st.meas = asl_pkg::MEAS_SECOND;
          end
        end
        asl_pkg::MEAS_SECOND: begin
          if (rxEdge) begin
            next_st.bitPer = asl_pkg::PERIOD_W'(st.gapCnt + 1'b1); // see RQ8
            next_st.meas   = asl_pkg::MEAS_RUN;
          end
        end
        asl_pkg::MEAS_RUN: begin
          if (!rxEdge && (st.gapCnt > gapLimit)) begin
            next_st.stat[asl_pkg::TIMEOUT_BIT] = 1'b1; // see RQ7
            next_st.meas = asl_pkg::MEAS_IDLE;
          end
        end
      endcase
      if (!packetActive) begin
        next_st.meas = asl_pkg::MEAS_IDLE;
      end
    end
  end

  // ----------------------------------------
  // registers and outputs
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      st         <= '0;
      st.sync    <= asl_pkg::SYNC_RESET;
      st.rxLevel <= asl_pkg::LINE_IDLE;
      st.codes   <= asl_pkg::CODES_RESET;
      st.stat    <= asl_pkg::STATUS_RESET; // see RQ6
      st.meas    <= asl_pkg::MEAS_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign regRdata        = st.rdata;
  assign deviceId        = {st.codes[5:4], st.codes[3:0]}; // see RQ3 see RQ4
  assign strap0LowFlag   = st.lowFlag;
  assign watchdogExpired = st.stat[asl_pkg::WDOG_BIT];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  strap_hold_a: assert property (st.sampled |=> $stable(st.codes)) // see RQ10
    else $error("strap codes changed after sampling");
  low_flag_a: assert property (ce && strapValid && !st.sampled |=>
      strap0LowFlag == ($past(strap0Value) < asl_pkg::STRAP_MIN_CODE)) // see RQ1
    else $error("strap 0 low flag wrong");
  code_read_a: assert property (ce && st.sampled && regRead && regAddr == asl_pkg::STRAP_CODES_ADDR
      |=> regRdata == {1'b0, st.codes}) // see RQ2
    else $error("strap code read wrong");
  id_low_a: assert property (ce && strapValid && !st.sampled |=>
      deviceId[3:0] == $past(strap0Value) && deviceId[5:4] == $past(strap1Value[1:0])) // see RQ4
    else $error("device id does not follow straps");
  flag_keep_a: assert property (ce && st.stat[asl_pkg::CRC_BIT] && !statusWrite
      |=> st.stat[asl_pkg::CRC_BIT]) // see RQ6
    else $error("error flag lost without write");
  flag_clear_a: assert property (ce && statusWrite && regWdata[asl_pkg::PL_STOP_BIT] && !payloadStopErr
      |=> !st.stat[asl_pkg::PL_STOP_BIT]) // see RQ6
    else $error("write one did not clear");
  crc_set_a: assert property (ce && crcErr |=> st.stat[asl_pkg::CRC_BIT]) // see RQ9
    else $error("checksum error not flagged");
  wdog_set_a: assert property (ce && !rxEdge && st.wdCnt == WDOG_LAST |=> watchdogExpired) // see RQ5
    else $error("watchdog did not expire");
  wdog_early_a: assert property (ce && rxEdge && !statusWrite ##1 !watchdogExpired
      |=> !watchdogExpired) // see RQ5
    else $error("watchdog set right after activity");
  timeout_set_a: assert property (ce && packetActive && st.meas == asl_pkg::MEAS_RUN && !rxEdge
      && st.gapCnt > gapLimit |=> st.stat[asl_pkg::TIMEOUT_BIT]) // see RQ7
    else $error("receive timeout not flagged");

  wdog_cover_c: cover property (watchdogExpired);
  timeout_cover_c: cover property (st.stat[asl_pkg::TIMEOUT_BIT]);
  clear_cover_c: cover property (statusWrite && st.stat != '0);
  period_cover_c: cover property (st.meas == asl_pkg::MEAS_RUN);

endmodule // asl_status
`default_nettype wire

// *** tb/asl_link_model.sv ***
/*
  receive line model for the status bank bench: toggles the serial pin.
  assumes the bench raises run only to show line activity or a packet.
*/
`timescale 1ns/1ps
`default_nettype none
module asl_link_model #(
  parameter int unsigned HALF = 4
) (
  input  wire logic clock,
  input  wire logic run,
  output var  logic rxPin
);
  int cnt = 0;
  initial rxPin = 1'b1;
  // ----------------------------------------
  // line driver
  // ----------------------------------------
  // alternating pattern, so edge spacing is one bit period
  always @(posedge clock) begin
    if (!run) begin
      cnt   <= 0;
      rxPin <= 1'b1; // idle high, pulled up
    end else if (cnt == HALF - 1) begin
      cnt   <= 0;
      rxPin <= ~rxPin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule // asl_link_model
`default_nettype wire

// *** tb/asl_status_tb.sv ***
/*
  self-checking bench for the strap code and link status registers.
  assumes asl_status with a short watchdog count and the link model.
*/
`timescale 1ns/1ps
`default_nettype none
module asl_status_tb;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic        run = 1'b0;
  logic        ce = 1'b1;
  logic        rxPin;
  logic        packetActive = 1'b0;
  logic        strapValid = 1'b0;
  logic [3:0]  s0 = 4'h0, s1 = 4'h0, s2 = 4'h0;
  logic [5:0]  errs = 6'h00;
  logic        regRead = 1'b0, regWrite = 1'b0;
  logic [3:0]  regAddr = 4'h0;
  logic [12:0] regWdata = 13'h0000;
  logic [12:0] regRdata;
  logic [5:0]  deviceId;
  logic        lowFlag, wdOut;
  int          mismatches = 0;
  int          checkCount = 0;
  always #20 clock = ~clock;
  asl_link_model u_asl_link_model (.clock(clock), .run(run), .rxPin(rxPin));
  asl_status #(.WDOG_CYCLES(200)) u_asl_status (
    .clock(clock), .resetn(resetn), .ce(ce), .rxPin(rxPin), .packetActive(packetActive),
    .strapValid(strapValid), .strap0Value(s0), .strap1Value(s1), .strap2Value(s2),
    .crcErr(errs[5]), .syncParityErr(errs[4]), .payloadParityErr(errs[3]), .syncStopErr(errs[2]),
    .payloadStopErr(errs[1]), .payloadStartErr(errs[0]), .regRead(regRead), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .deviceId(deviceId),
    .strap0LowFlag(lowFlag), .watchdogExpired(wdOut));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    checkCount++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic rd(input logic [3:0] a, output logic [12:0] d);
    cyc(1);
    regRead = 1'b1;
    regAddr = a;
    cyc(1);
    regRead = 1'b0;
    d = regRdata;
  endtask
  task automatic wr(input logic [3:0] a, input logic [12:0] d);
    cyc(1);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    cyc(1);
    regWrite = 1'b0;
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checkCount, mismatches);
    if (mismatches == 0 && checkCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_strap();
    logic [12:0] d;
    rd(4'hd, d);
    chk(d, 13'h0000);
    s1 = 4'h5;
    s2 = 4'ha;
    strapValid = 1'b1;
    cyc(1);
    strapValid = 1'b0;
    s0 = 4'h3;
    s1 = 4'h3;
    s2 = 4'h3;
    cyc(1);
    strapValid = 1'b1; // late strobe must not resample
    cyc(1);
    strapValid = 1'b0;
    wr(4'hc, 13'h1fff);
    rd(4'hc, d);
    chk(d, 13'h0a50);
    chk({7'h00, deviceId}, 13'h0010);
    chk({12'h000, lowFlag}, 13'h0001);
    rd(4'h3, d);
    chk(d, 13'h0000);
  endtask
  task automatic t_errors();
    logic [12:0] d;
    for (int k = 0; k < 6; k++) begin
      cyc(1);
      errs = 6'h01 << k;
      cyc(1);
      errs = 6'h00;
      rd(4'hd, d);
      chk(d, 13'h0002 << k);
      wr(4'hd, 13'h0000);
      rd(4'hd, d);
      chk(d, 13'h0002 << k);
      wr(4'hd, 13'h0002 << k);
      rd(4'hd, d);
      chk(d, 13'h0000);
    end
  endtask
  task automatic t_freeze();
    logic [12:0] d;
    ce = 1'b0; // frozen block must ignore an error pulse
    errs = 6'h20;
    cyc(1);
    errs = 6'h00;
    ce = 1'b1;
    rd(4'hd, d);
    chk(d, 13'h0000);
  endtask
  task automatic t_watchdog();
    logic [12:0] d;
    run = 1'b0;
    cyc(150);
    chk({12'h000, wdOut}, 13'h0000);
    cyc(80);
    chk({12'h000, wdOut}, 13'h0001);
    rd(4'hd, d);
    chk(d, 13'h0100);
    run = 1'b1; // activity first, else the flag re-arms
    cyc(10);
    wr(4'hd, 13'h0100);
    rd(4'hd, d);
    chk(d, 13'h0000);
  endtask
  task automatic t_timeout();
    logic [12:0] d;
    packetActive = 1'b1;
    cyc(30);
    run = 1'b0; // line stalls mid-packet, bit period 4 cycles
    cyc(40);
    rd(4'hd, d);
    chk(d, 13'h0000);
    cyc(60);
    rd(4'hd, d);
    chk(d, 13'h0080);
    packetActive = 1'b0;
    run = 1'b1;
    wr(4'hd, 13'h0080);
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    #1;
    resetn = 1'b1;
    run = 1'b1; // keeps the short line watchdog quiet
    t_strap();
    t_errors();
    t_freeze();
    t_watchdog();
    t_timeout();
    close_out();
  end
  initial begin
    #2_000_000;
    mismatches++;
    close_out();
  end
endmodule // asl_status_tb
`default_nettype wire
